// *** iptc_pkg.sv ***
// package: constants and types for the interrupt priority and trap controller
package iptc_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_SRC = 16;
  localparam int NUM_EXT = 5;
  localparam int PRIO_W = 3;
  localparam int LVL_W = 4;
  localparam int VEC_W = 7;
  // register byte offsets
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_CORE = 12'h004;
  localparam logic [11:0] OFS_CTL1 = 12'h008;
  localparam logic [11:0] OFS_CTL2 = 12'h00C;
  localparam logic [11:0] OFS_FLAG = 12'h010;
  localparam logic [11:0] OFS_ENABLE = 12'h014;
  localparam logic [11:0] OFS_PRIO0 = 12'h018;
  localparam logic [11:0] OFS_PRIO1 = 12'h01C;
  localparam logic [11:0] OFS_PRIO2 = 12'h020;
  localparam logic [11:0] OFS_PRIO3 = 12'h024;
  localparam logic [11:0] OFS_LATCH = 12'h028;
  // field positions
  localparam int STAT_PRIO_LSB = 5;
  localparam int CORE_TOP_BIT = 3;
  localparam int C1_NEST_DIS = 15;
  localparam int C1_OVA = 14;
  localparam int C1_OVB = 13;
  localparam int C1_COVA = 12;
  localparam int C1_COVB = 11;
  localparam int C1_OVA_EN = 10;
  localparam int C1_OVB_EN = 9;
  localparam int C1_COV_EN = 8;
  localparam int C1_SHIFT = 7;
  localparam int C1_DIV = 6;
  localparam int C1_DMA = 5;
  localparam int C1_MATH = 4;
  localparam int C1_ADDR = 3;
  localparam int C1_STACK = 2;
  localparam int C1_OSC = 1;
  localparam int C2_ALT_TABLE = 15;
  localparam int LATCH_LVL_LSB = 8;
  localparam int SRC_PER_PRIO_REG = 4;
  localparam int PRIO_FIELD_STRIDE = 4;
  // reset values and fixed codes
  localparam logic [15:0] CTL1_RESET = 16'h0000;
  localparam logic [15:0] CTL2_RESET = 16'h0000;
  localparam logic [15:0] CTL1_WMASK = 16'hFFFE;
  localparam logic [15:0] CTL2_WMASK = 16'h801F;
  localparam logic [2:0] PRIO_LOW_MAX = 3'h7;
  localparam logic [6:0] FIRST_USER_VECTOR = 7'h08;

  typedef struct packed {
    logic acc_a_ovf;
    logic acc_b_ovf;
    logic acc_a_cat;
    logic acc_b_cat;
    logic shift_err;
    logic div_zero;
    logic dma_err;
    logic addr_err;
    logic stack_err;
    logic osc_fail;
  } iptc_trap_ev_t;
endpackage

// *** iptc_top.sv ***
// module: interrupt priority selection, trap status and their registers over apb
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// How it works
// (RQ1) each source has a request flag set by hardware, cleared only by software
// (RQ2) each source has an enable bit; disabled sources never interrupt the core
// (RQ3) each user source takes one of eight priority levels from its field
// (RQ4) selected vector number and its level latch into a readable register
// (RQ5) latched level equals the programmed priority of the selected source
// (RQ6) sources map to flag, enable and priority bits in natural order
// (RQ7) low three cpu priority bits sit in status bits 7..5, software writable
// (RQ8) top cpu priority bit sits in core control bit 3, read-only
// (RQ9) cpu level is top bit joined to low bits; top set blocks user interrupts
// (RQ10) low field 111 means level 7 or 15, all user interrupts blocked
// (RQ11) low priority field is read-only while nesting disable is set
// (RQ12) control one bit 15 set disables nesting, clear allows it
// (RQ13) bits 14 and 13 flag accumulator a and b overflow traps
// (RQ14) bits 12 and 11 flag catastrophic overflow of accumulator a and b
// (RQ15) overflow traps need bits 10 or 9; bit 8 enables catastrophic traps
// (RQ16) bit 7 flags a math trap from an invalid accumulator shift
// (RQ17) bit 6 flags a math trap from divide by zero
// (RQ18) bit 5 flags a dma controller error trap, clear otherwise
// (RQ19) bit 4 flags any math error trap
// (RQ20) control two holds external edge polarity and alternate table select
// (RQ21) bits 3, 2, 1 flag address, stack, oscillator traps; bit 0 reads zero
// (RQ22) control two bit 15 selects the alternate vector table
// (RQ23) external polarity bit one detects falling edge, zero rising edge
// (RQ24) request goes to the core only when priority exceeds cpu level
module iptc_top (
  input wire logic pclk, // system clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [iptc_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [iptc_pkg::NUM_EXT-1:0] ext_irq, // external interrupt pins
  input wire logic [iptc_pkg::NUM_SRC-1:0] periph_irq, // peripheral request pulses
  input wire iptc_pkg::iptc_trap_ev_t trap_ev, // trap event pulses from the core
  input wire logic irq_ack, // core takes the presented interrupt
  input wire logic trap_return, // core leaves trap level
  output logic irq_req, // interrupt presented to the core
  output logic [iptc_pkg::VEC_W-1:0] irq_vector, // vector of presented interrupt
  output logic [iptc_pkg::LVL_W-1:0] irq_level, // level of presented interrupt
  output logic trap_req, // a trap was taken this cycle
  output logic alt_table // alternate vector table in use
);
  import iptc_pkg::*;

  logic [PRIO_W-1:0] cpu_priority_low;
  logic cpu_priority_top;
  logic [15:0] interrupt_control_one;
  logic [15:0] interrupt_control_two;
  logic [NUM_SRC-1:0] request_flag_reg;
  logic [NUM_SRC-1:0] source_enable_reg;
  logic [PRIO_W-1:0] source_priority [NUM_SRC];
  logic [VEC_W-1:0] pending_vector_number;
  logic [LVL_W-1:0] pending_level;
  logic [NUM_EXT-1:0] ext_meta;
  logic [NUM_EXT-1:0] ext_sync;
  logic [NUM_EXT-1:0] ext_prev;

  // apb decode
  wire wr_en = psel & penable & pwrite & pready;
  wire setup = psel & ~penable;
  wire hit_status = paddr == OFS_STATUS;
  wire hit_core = paddr == OFS_CORE;
  wire hit_ctl1 = paddr == OFS_CTL1;
  wire hit_ctl2 = paddr == OFS_CTL2;
  wire hit_flag = paddr == OFS_FLAG;
  wire hit_enable = paddr == OFS_ENABLE;
  wire hit_prio0 = paddr == OFS_PRIO0;
  wire hit_prio1 = paddr == OFS_PRIO1;
  wire hit_prio2 = paddr == OFS_PRIO2;
  wire hit_prio3 = paddr == OFS_PRIO3;
  wire hit_latch = paddr == OFS_LATCH;
  wire hit_prio = hit_prio0 | hit_prio1 | hit_prio2 | hit_prio3;
  wire mapped = hit_status | hit_core | hit_ctl1 | hit_ctl2 | hit_flag | hit_enable
    | hit_prio | hit_latch;
  wire [1:0] prio_reg_sel = {hit_prio2 | hit_prio3, hit_prio1 | hit_prio3};
  wire nest_disabled = interrupt_control_one[C1_NEST_DIS];

  // (RQ23) edge detect on synchronised external pins, polarity per pin
  wire [NUM_EXT-1:0] ext_pol = interrupt_control_two[NUM_EXT-1:0];
  wire [NUM_EXT-1:0] ext_edge = (ext_pol & ext_prev & ~ext_sync)
    | (~ext_pol & ~ext_prev & ext_sync);

  // (RQ6) external pins land on the lowest flag positions
  wire [NUM_SRC-1:0] src_set = periph_irq | {{(NUM_SRC-NUM_EXT){1'b0}}, ext_edge};

  // (RQ9) four-bit cpu level from top bit and low field
  wire [LVL_W-1:0] cpu_level = {cpu_priority_top, cpu_priority_low};

  // (RQ24) pick the eligible source with the highest priority, lowest index on ties
  logic [NUM_SRC-1:0] eligible;
  logic best_found;
  logic [3:0] best_idx;
  logic [PRIO_W-1:0] best_prio;
  always_comb begin
    best_found = 1'b0;
    best_idx = 4'h0;
    best_prio = 3'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // (RQ2) enable gates each flag
      // (RQ10) low field 111 leaves no user level above it
      eligible[i] = request_flag_reg[i] & source_enable_reg[i]
        & ({1'b0, source_priority[i]} > cpu_level);
      if (eligible[i] && (!best_found || source_priority[i] > best_prio)) begin
        best_found = 1'b1;
        best_idx = 4'(i);
        best_prio = source_priority[i];
      end
    end
  end
  wire [VEC_W-1:0] best_vector = FIRST_USER_VECTOR + {3'h0, best_idx};
  wire take_irq = irq_ack & irq_req;

  // trap conditions
  // (RQ15) overflow traps gated by their own enables, catastrophic by a shared one
  wire ova_trap = trap_ev.acc_a_ovf & interrupt_control_one[C1_OVA_EN];
  wire ovb_trap = trap_ev.acc_b_ovf & interrupt_control_one[C1_OVB_EN];
  wire cova_trap = trap_ev.acc_a_cat & interrupt_control_one[C1_COV_EN];
  wire covb_trap = trap_ev.acc_b_cat & interrupt_control_one[C1_COV_EN];
  // (RQ19) any arithmetic cause is a math error trap
  wire math_trap = ova_trap | ovb_trap | cova_trap | covb_trap
    | trap_ev.shift_err | trap_ev.div_zero;
  wire any_trap = math_trap | trap_ev.dma_err | trap_ev.addr_err
    | trap_ev.stack_err | trap_ev.osc_fail;

  logic [15:0] ctl1_set;
  always_comb begin
    ctl1_set = 16'h0000;
    // (RQ13) accumulator overflow causes
    ctl1_set[C1_OVA] = ova_trap;
    ctl1_set[C1_OVB] = ovb_trap;
    // (RQ14) catastrophic overflow causes
    ctl1_set[C1_COVA] = cova_trap;
    ctl1_set[C1_COVB] = covb_trap;
    // (RQ16) invalid shift cause
    ctl1_set[C1_SHIFT] = trap_ev.shift_err;
    // (RQ17) divide by zero cause
    ctl1_set[C1_DIV] = trap_ev.div_zero;
    // (RQ18) dma controller error
    ctl1_set[C1_DMA] = trap_ev.dma_err;
    ctl1_set[C1_MATH] = math_trap;
    // (RQ21) address, stack and oscillator traps
    ctl1_set[C1_ADDR] = trap_ev.addr_err;
    ctl1_set[C1_STACK] = trap_ev.stack_err;
    ctl1_set[C1_OSC] = trap_ev.osc_fail;
  end

  // software writes, hardware sets win over a cleared bit in the same cycle
  wire [15:0] ctl1_wr = wr_en && hit_ctl1 ? pwdata[15:0] & CTL1_WMASK : interrupt_control_one;
  wire [15:0] next_ctl1 = ctl1_wr | ctl1_set;
  // (RQ20) control two keeps only polarity and table select
  wire [15:0] next_ctl2 = wr_en && hit_ctl2 ? pwdata[15:0] & CTL2_WMASK
    : interrupt_control_two;
  // (RQ1) flags set by sources, cleared only through a register write
  wire [NUM_SRC-1:0] next_flag = (wr_en && hit_flag ? pwdata[NUM_SRC-1:0]
    : request_flag_reg) | src_set;
  wire [NUM_SRC-1:0] next_enable = wr_en && hit_enable ? pwdata[NUM_SRC-1:0]
    : source_enable_reg;

  // (RQ7) software may rewrite the low field; (RQ11) not while nesting is disabled
  wire sw_prio_wr = wr_en & hit_status & ~nest_disabled;
  logic [PRIO_W-1:0] next_prio_low;
  always_comb begin
    next_prio_low = cpu_priority_low;
    if (sw_prio_wr) begin
      next_prio_low = pwdata[STAT_PRIO_LSB +: PRIO_W];
    end
    // (RQ12) taken interrupt raises the level; nesting disabled forces the maximum
    if (take_irq) begin
      next_prio_low = nest_disabled ? PRIO_LOW_MAX : irq_level[PRIO_W-1:0];
    end
  end

  // (RQ8) top bit follows trap entry and exit only, never software
  wire next_top = any_trap | (cpu_priority_top & ~trap_return);

  // read mux
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (hit_status) begin
      rd_word[STAT_PRIO_LSB +: PRIO_W] = cpu_priority_low;
    end
    if (hit_core) begin
      rd_word[CORE_TOP_BIT] = cpu_priority_top;
    end
    if (hit_ctl1) begin
      rd_word = interrupt_control_one;
    end
    if (hit_ctl2) begin
      rd_word = interrupt_control_two;
    end
    if (hit_flag) begin
      rd_word = request_flag_reg;
    end
    if (hit_enable) begin
      rd_word = source_enable_reg;
    end
    if (hit_prio) begin
      for (int k = 0; k < SRC_PER_PRIO_REG; k++) begin
        rd_word[k*PRIO_FIELD_STRIDE +: PRIO_W] =
          source_priority[{prio_reg_sel, 2'(k)}];
      end
    end
    // (RQ4) latch register shows vector and level
    if (hit_latch) begin
      rd_word[VEC_W-1:0] = pending_vector_number;
      rd_word[LATCH_LVL_LSB +: LVL_W] = pending_level;
    end
  end

  // external pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= '0;
      ext_sync <= '0;
      ext_prev <= '0;
    end else begin
      ext_meta <= ext_irq;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // control and status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control_one <= CTL1_RESET;
      interrupt_control_two <= CTL2_RESET;
      request_flag_reg <= '0;
      source_enable_reg <= '0;
      cpu_priority_low <= '0;
      cpu_priority_top <= 1'b0;
    end else begin
      interrupt_control_one <= next_ctl1;
      interrupt_control_two <= next_ctl2;
      request_flag_reg <= next_flag;
      source_enable_reg <= next_enable;
      cpu_priority_low <= next_prio_low;
      cpu_priority_top <= next_top;
    end
  end

  // (RQ3) per-source priority fields, four to a register word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        source_priority[i] <= '0;
      end
    end else if (wr_en && hit_prio) begin
      for (int k = 0; k < SRC_PER_PRIO_REG; k++) begin
        source_priority[{prio_reg_sel, 2'(k)}] <= pwdata[k*PRIO_FIELD_STRIDE +: PRIO_W];
      end
    end
  end

  // (RQ5) latch vector and priority of the selected source when the core takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_vector_number <= '0;
      pending_level <= '0;
    end else if (take_irq) begin
      pending_vector_number <= irq_vector;
      pending_level <= irq_level;
    end
  end

  // core-facing outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_vector <= '0;
      irq_level <= '0;
      trap_req <= 1'b0;
      alt_table <= 1'b0;
    end else begin
      // (RQ9) blocked while a trap level is active
      irq_req <= best_found & ~take_irq & ~next_top;
      irq_vector <= best_vector;
      irq_level <= {1'b0, best_prio};
      trap_req <= any_trap;
      // (RQ22) table select for vector fetch
      alt_table <= next_ctl2[C2_ALT_TABLE];
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup && !pwrite ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end
endmodule

// *** iptc_top_monitor.sv ***
// checker: apb timing, trap and interrupt request relations
`timescale 1ns/1ps
module iptc_top_monitor (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [iptc_pkg::ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [iptc_pkg::NUM_EXT-1:0] ext_irq, // pins
  input wire logic [iptc_pkg::NUM_SRC-1:0] periph_irq, // requests
  input wire iptc_pkg::iptc_trap_ev_t trap_ev, // trap events
  input wire logic irq_ack, // core take
  input wire logic trap_return, // trap exit
  input wire logic irq_req, // presented request
  input wire logic [iptc_pkg::VEC_W-1:0] irq_vector, // vector
  input wire logic [iptc_pkg::LVL_W-1:0] irq_level, // level
  input wire logic trap_req, // trap taken
  input wire logic alt_table // table select
);
  import iptc_pkg::*;
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire done = psel && penable && pready;
  wire plain_trap = trap_ev.shift_err || trap_ev.div_zero || trap_ev.dma_err ||
    trap_ev.addr_err || trap_ev.stack_err || trap_ev.osc_fail;
  a_ready_after_setup: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_idle_read_zero: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (setup && paddr > OFS_LATCH |=> pslverr)
    else $error("unmapped address not refused");
  a_alt_follows_write: assert property (
    done && pwrite && paddr == OFS_CTL2 |=> alt_table == $past(pwdata[15]))
    else $error("table select does not follow write");
  a_trap_pulse: assert property (plain_trap |=> trap_req)
    else $error("ungated trap event without trap pulse");
  a_trap_blocks_irq: assert property (
    trap_req && !trap_return && !$past(trap_return) |=> !irq_req)
    else $error("interrupt presented at trap level");
  a_ack_drops_req: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request held after acknowledge");
  a_req_user_level: assert property (
    irq_req |-> irq_vector >= FIRST_USER_VECTOR && irq_vector < 7'h18 &&
    irq_level != 4'h0 && !irq_level[3])
    else $error("presented vector or level out of range");
  c_trap: cover property (trap_req);
  c_ack: cover property (irq_req && irq_ack);
  c_err: cover property (pslverr);
endmodule

// *** iptc_core_model.sv ***
// core model: takes presented interrupts after a delay, leaves trap level
`timescale 1ns/1ps
module iptc_core_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic irq_req, // presented request
  input wire logic ack_en, // taking allowed
  input wire logic [1:0] ack_delay, // cycles before taking
  input wire logic ret_cmd, // trap exit order
  output logic irq_ack, // take pulse
  output logic trap_return // exit pulse
);
  logic [1:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      trap_return <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      trap_return <= ret_cmd;
      irq_ack <= 1'b0;
      if (ack_en && irq_req && !irq_ack) begin
        if (wait_cnt == ack_delay) begin
          irq_ack <= 1'b1;
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule

// *** iptc_top_bench.sv ***
// bench: registers, priority choice, traps and pin edges against a model
`timescale 1ns/1ps
module iptc_top_bench;
  import iptc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, irq_ack, trap_return, ack_en, ret_cmd;
  logic pready, pslverr, irq_req, trap_req, alt_table, err_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [4:0] ext_irq;
  logic [15:0] periph_irq;
  logic [6:0] irq_vector;
  logic [3:0] irq_level;
  logic [1:0] ack_delay;
  iptc_trap_ev_t trap_ev;
  int err_count, tests_run, m_low, m_top, m_c1, m_c2, m_flag, m_en, m_latch, b, lvl, nest, j;
  int m_prio[16];
  int gate[10] = '{-1, -1, -1, -1, -1, -1, 8, 8, 9, 10};
  int pos[10] = '{1, 2, 3, 5, 6, 7, 11, 12, 13, 14};
  iptc_top i_iptc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq(ext_irq), .periph_irq(periph_irq), .trap_ev(trap_ev),
    .irq_ack(irq_ack), .trap_return(trap_return), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .trap_req(trap_req),
    .alt_table(alt_table));
  iptc_core_model i_iptc_core_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .ack_en(ack_en), .ack_delay(ack_delay), .ret_cmd(ret_cmd), .irq_ack(irq_ack),
    .trap_return(trap_return));
  function automatic int exp_reg(int i);
    case (i)
      0: return m_low << 5;
      1: return m_top << 3;
      2: return m_c1;
      3: return m_c2;
      4: return m_flag;
      5: return m_en;
      10: return m_latch;
      default: return m_prio[i*4-24] | m_prio[i*4-23] << 4 | m_prio[i*4-22] << 8 |
        m_prio[i*4-21] << 12;
    endcase
  endfunction
  function automatic void mwr(int i, int d);
    case (i)
      0: if (!m_c1[15]) m_low = d >> 5 & 7;
      2: m_c1 = d & CTL1_WMASK;
      3: m_c2 = d & CTL2_WMASK;
      4: m_flag = d & 32'hFFFF;
      5: m_en = d & 32'hFFFF;
      default: if (i > 5 && i < 10) for (int k = 0; k < 4; k++) m_prio[i*4-24+k] = d >> 4*k & 7;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input int i, input int d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 12'(i * 4);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w) mwr(i, d);
    @(posedge pclk);
  endtask
  task automatic wr(int i, int d);
    apb(1'b1, i, d);
  endtask
  task automatic rd(int i);
    apb(1'b0, i, 0);
    chk({rd_v[31:1], err_v ^ rd_v[0]}, exp_reg(i));
  endtask
  task automatic summarize();
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, ack_en, ret_cmd, paddr, pwdata} = '0;
    {ext_irq, periph_irq, ack_delay, trap_ev} = '0;
    void'($urandom(32'h13BE));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 11; i++) rd(i);
    apb(1'b0, 11, 0);
    chk({rd_v[30:0], err_v}, 32'h1);
    repeat (40) wr($urandom % 10, $urandom);
    for (int i = 0; i < 11; i++) rd(i);
    for (int r = 0; r < 16; r++) begin
      lvl = $urandom % 8;
      nest = $urandom % 2;
      wr(2, 0);
      wr(0, lvl << 5);
      wr(2, nest << 15);
      wr(5, r < 4 ? 32'hFFFF : $urandom);
      for (int i = 6; i < 10; i++) wr(i, $urandom & 32'h7777);
      wr(4, 0);
      periph_irq <= 16'($urandom);
      @(posedge pclk);
      m_flag = periph_irq;
      periph_irq <= 16'h0;
      b = -1;
      for (int i = 0; i < 16; i++)
        if (m_flag[i] && m_en[i] && m_prio[i] > lvl && (b < 0 || m_prio[i] > m_prio[b])) b = i;
      repeat (4) if (irq_req !== 1'b1) @(posedge pclk);
      chk(32'(irq_req), 32'(b >= 0));
      if (b >= 0) begin
        chk(32'(irq_vector), 32'(b + 8));
        chk(32'(irq_level), 32'(m_prio[b]));
        ack_delay <= 2'(r);
        ack_en <= 1'b1;
        repeat (8) if (irq_ack !== 1'b1) @(posedge pclk);
        ack_en <= 1'b0;
        m_latch = m_prio[b] << 8 | (b + 8);
        m_low = nest ? 7 : m_prio[b];
        @(posedge pclk);
        rd(10);
        rd(0);
      end
    end
    wr(2, 0);
    wr(0, 0);
    wr(5, 32'hFFFF);
    wr(6, 32'h7777);
    wr(4, 32'hFFFF);
    for (int i = 0; i < 20; i++) begin
      j = i % 10;
      wr(2, i < 10 ? 32'h0700 : 0);
      trap_ev <= iptc_trap_ev_t'(10'(1 << j));
      @(posedge pclk);
      trap_ev <= '0;
      if (gate[j] < 0 || m_c1[gate[j]]) begin
        m_c1 = m_c1 | 1 << pos[j] | (j > 3 ? 16 : 0);
        m_top = 1;
      end
      @(posedge pclk);
      rd(2);
      rd(1);
      ret_cmd <= 1'b1;
      @(posedge pclk);
      ret_cmd <= 1'b0;
      m_top = 0;
      repeat (3) @(posedge pclk);
      rd(1);
    end
    wr(5, 0);
    for (int i = 0; i < 10; i++) begin
      wr(3, (i % 2) << (i / 2));
      ext_irq <= 5'((i % 2) << (i / 2));
      repeat (6) @(posedge pclk);
      wr(4, 0);
      ext_irq <= 5'((1 - i % 2) << (i / 2));
      repeat (6) @(posedge pclk);
      m_flag = 1 << (i / 2);
      rd(4);
      wr(4, 0);
      ext_irq <= 5'((i % 2) << (i / 2));
      repeat (6) @(posedge pclk);
      rd(4);
    end
    summarize();
  end
endmodule
bind iptc_top iptc_top_monitor i_iptc_top_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq(ext_irq),
  .periph_irq(periph_irq), .trap_ev(trap_ev), .irq_ack(irq_ack),
  .trap_return(trap_return), .irq_req(irq_req), .irq_vector(irq_vector),
  .irq_level(irq_level), .trap_req(trap_req), .alt_table(alt_table));
